// [hdl/hsf_pkg.sv]
// hot swap control package: pin map of the synchroniser, reset values, fsm states
// assumes every user of it imports it whole or names items with hsf_pkg::
package hsf_pkg;

    // ==========================================================
    // synchronised pin bundle
    localparam int SYNC_WIDTH = 6;
    localparam int PIN_HEALTHY_N = 0;
    localparam int PIN_PCI_RST_N = 1;
    localparam int PIN_LRST_IN_N = 2;
    localparam int PIN_LATCH = 3;
    localparam int PIN_HOLD_OPT = 4;
    localparam int PIN_BURST_OPT_N = 5;
    // back end unpowered, pci reset active, local reset idle, latch closed, no hold
    // local reset in rests at its idle level so no false rise follows nrst
    localparam logic [SYNC_WIDTH-1:0] SYNC_RESET = 6'h2d;

    // ==========================================================
    // output register values after reset
    localparam logic LAMP_OE_N_RESET = 1'h0;
    localparam logic ENUM_OE_N_RESET = 1'h1;
    localparam logic LRST_OUT_N_RESET = 1'h0;
    localparam logic LRST_OE_N_RESET = 1'h1;
    localparam logic HOLD_RESET = 1'h0;
    localparam logic BURST_OPT_N_RESET = 1'h1;
    localparam logic FLAG_RESET = 1'h0;

    // ==========================================================
    // insertion sequencer
    typedef enum logic [2:0] {
        ST_POWERED_DOWN,
        ST_WAIT_PCI,
        ST_LOADING,
        ST_RELEASE,
        ST_HOLDING,
        ST_RUNNING
    } hsf_state_type;

endpackage : hsf_pkg

// [hdl/hsf_sync2.sv]
// two flop synchroniser for the asynchronous hot swap pins
// assumes pins are quasi static; the first stage feeds only the second
`timescale 1ns/1ps
module hsf_sync2
    import hsf_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic [hsf_pkg::SYNC_WIDTH-1:0] pinsAsync,
    output logic [hsf_pkg::SYNC_WIDTH-1:0] pinsSync
);

    import hsf_pkg::*;

    logic [SYNC_WIDTH-1:0] meta_q;
    logic [SYNC_WIDTH-1:0] sync_q;

    // ==========================================================
    // two stages, reset to the safe powered-down pin picture
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            meta_q <= SYNC_RESET;
            sync_q <= SYNC_RESET;
        end
        else
        begin
            meta_q <= pinsAsync;
            sync_q <= meta_q;
        end
    end

    assign pinsSync = sync_q;

endmodule : hsf_sync2

// [hdl/hsf_flag_cell.sv]
// sticky status flag set by hardware, cleared by software or by internal reset
// assumes set, clear and flush are on the same clock as the cell
`timescale 1ns/1ps
module hsf_flag_cell
    import hsf_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic setPulse,
    input wire logic clrPulse,
    input wire logic flush,
    output logic flag
);

    import hsf_pkg::*;

    logic flag_q;

    // ==========================================================
    // set beats clear so an event in the clearing cycle survives
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            flag_q <= FLAG_RESET;
        else if (flush)
            flag_q <= FLAG_RESET;
        else if (setPulse)
            flag_q <= 1'h1;
        else if (clrPulse)
            flag_q <= FLAG_RESET;
    end

    assign flag = flag_q;

endmodule : hsf_flag_cell

// [hdl/hsf_hot_swap_ctrl.sv]
// card side hot swap control: lamp, event line, flags, internal and local reset
// assumes host write strobes and eeprom handshake are on clock; pins are async
`timescale 1ns/1ps
module hsf_hot_swap_ctrl
    import hsf_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic backendHealthyN,
    input wire logic pciRstN,
    input wire logic localResetInN,
    input wire logic ejectorLatchSense,
    input wire logic hostConfigHoldPin,
    input wire logic burstOptionPinN,
    input wire logic lampOnRequest,
    input wire logic enumEventMask,
    input wire logic insertionFlagWr,
    input wire logic extractionFlagWr,
    input wire logic enumEventMaskWr,
    input wire logic hostConfigHoldClr,
    input wire logic eepromLoadEnable,
    input wire logic eepromLoadDone,
    output logic statusLampDriveN,
    output logic statusLampOeN,
    output logic enumDriveN,
    output logic enumOeN,
    output logic localResetOutN,
    output logic localResetOeN,
    output logic internalReset,
    output logic insertionFlag,
    output logic extractionFlag,
    output logic hostConfigHold,
    output logic burstOptionN,
    output logic eepromLoadStart,
    output logic configAccept,
    output logic configRetry
);

    import hsf_pkg::*;

    logic [SYNC_WIDTH-1:0] pinsSync;
    logic healthyHigh;
    logic pciRstActive;
    logic lrstInN;
    logic latchClosed;
    logic healthyPrev_q;
    logic pciRstPrev_q;
    logic lrstInPrev_q;
    logic latchPrev_q;
    logic optionSample;
    logic latchOpened;
    logic latchReclosed;
    hsf_state_type state_q;
    hsf_state_type state_d;
    logic loadStart_d;
    logic loadStart_q;
    logic insSet;
    logic extSet;
    logic hostConfigHold_q;
    logic burstOptionN_q;
    logic lampOeN_q;
    logic enumOeN_q;
    logic lrstOutN_q;
    logic lrstOeN_q;

    // ==========================================================
    // pin synchronisation
    // latch through two flops before any edge logic
    hsf_sync2 u_sync (
        .clock(clock),
        .nrst(nrst),
        .pinsAsync({burstOptionPinN, hostConfigHoldPin, ejectorLatchSense,
                    localResetInN, pciRstN, backendHealthyN}),
        .pinsSync(pinsSync)
    );

    // latch high is closed, low is open
    assign latchClosed = pinsSync[PIN_LATCH];
    assign healthyHigh = pinsSync[PIN_HEALTHY_N];
    assign pciRstActive = !pinsSync[PIN_PCI_RST_N];
    assign lrstInN = pinsSync[PIN_LRST_IN_N];

    // internal reset from unpowered back end or pci reset
    assign internalReset = healthyHigh || pciRstActive;

    // ==========================================================
    // edge detection on synchronised levels only
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            healthyPrev_q <= SYNC_RESET[PIN_HEALTHY_N];
            pciRstPrev_q <= SYNC_RESET[PIN_PCI_RST_N];
            lrstInPrev_q <= SYNC_RESET[PIN_LRST_IN_N];
            latchPrev_q <= SYNC_RESET[PIN_LATCH];
        end
        else
        begin
            healthyPrev_q <= healthyHigh;
            pciRstPrev_q <= pinsSync[PIN_PCI_RST_N];
            lrstInPrev_q <= lrstInN;
            latchPrev_q <= latchClosed;
        end
    end

    // any of the three release edges samples the options
    assign optionSample = (healthyPrev_q && !healthyHigh)
        || (!pciRstPrev_q && !pciRstActive) || (!lrstInPrev_q && lrstInN);
    // falling edge of the latch means the handle opened
    assign latchOpened = latchPrev_q && !latchClosed;
    assign latchReclosed = !latchPrev_q && latchClosed;

    // ==========================================================
    // power-up option capture; a fresh sample beats a software clear
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            hostConfigHold_q <= HOLD_RESET;
            burstOptionN_q <= BURST_OPT_N_RESET;
        end
        // capture options at the release edge
        else if (optionSample)
        begin
            hostConfigHold_q <= pinsSync[PIN_HOLD_OPT];
            burstOptionN_q <= pinsSync[PIN_BURST_OPT_N];
        end
        else if (hostConfigHoldClr)
        begin
            hostConfigHold_q <= HOLD_RESET;
        end
    end

    // ==========================================================
    // insertion sequencer next state
    always_comb
    begin
        state_d = state_q;
        loadStart_d = 1'h0;
        insSet = 1'h0;
        // unpowered back end keeps the sequencer parked
        if (healthyHigh)
            state_d = ST_POWERED_DOWN;
        // powered but pci reset still active: wait for its release
        else if (pciRstActive)
            state_d = ST_WAIT_PCI;
        else
        begin
            case (state_q)
                ST_POWERED_DOWN, ST_WAIT_PCI:
                begin
                    // load only when the load option is on
                    loadStart_d = eepromLoadEnable;
                    state_d = eepromLoadEnable ? ST_LOADING : ST_RELEASE;
                end
                ST_LOADING:
                begin
                    if (eepromLoadDone)
                        state_d = ST_RELEASE;
                end
                ST_RELEASE, ST_HOLDING:
                begin
                    // retry configuration until the hold is cleared
                    if (hostConfigHold_q)
                        state_d = ST_HOLDING;
                    else
                    begin
                        // loading over: insertion flag and config access
                        state_d = ST_RUNNING;
                        insSet = 1'h1;
                    end
                end
                ST_RUNNING:
                begin
                    // reclosed latch with lamp requested sets the insertion flag again; state stays running
                    insSet = latchReclosed && lampOnRequest;
                end
                default:
                    state_d = ST_POWERED_DOWN;
            endcase
        end
    end

    // sequencer state and load strobe
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            state_q <= ST_POWERED_DOWN;
            loadStart_q <= 1'h0;
        end
        else
        begin
            state_q <= state_d;
            loadStart_q <= loadStart_d;
        end
    end

    assign eepromLoadStart = loadStart_q;
    assign configAccept = (state_q == ST_RUNNING);
    assign configRetry = (state_q == ST_HOLDING) || (state_q == ST_RELEASE);
    assign hostConfigHold = hostConfigHold_q;
    assign burstOptionN = burstOptionN_q;

    // ==========================================================
    // status flags
    // only a running card reports an opened handle
    assign extSet = latchOpened && (state_q == ST_RUNNING) && !internalReset;

    // write to the flag or the mask releases the insertion event
    hsf_flag_cell u_insFlag (
        .clock(clock),
        .nrst(nrst),
        .setPulse(insSet),
        .clrPulse(insertionFlagWr || enumEventMaskWr),
        .flush(internalReset),
        .flag(insertionFlag)
    );

    // host write clears the extraction flag
    hsf_flag_cell u_extFlag (
        .clock(clock),
        .nrst(nrst),
        .setPulse(extSet),
        .clrPulse(extractionFlagWr),
        .flush(internalReset),
        .flag(extractionFlag)
    );

    // ==========================================================
    // open-drain pin enables; lamp and event line always drive low, local reset drives lrstOutN_q
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            lampOeN_q <= LAMP_OE_N_RESET;
            enumOeN_q <= ENUM_OE_N_RESET;
            lrstOutN_q <= LRST_OUT_N_RESET;
            lrstOeN_q <= LRST_OE_N_RESET;
        end
        else
        begin
            // lamp lit unpowered or on request; floats otherwise
            // lamp keeps its drive while the other pins float
            lampOeN_q <= !(healthyHigh || lampOnRequest);
            // event pulled low only for an unmasked flag
            // healthy high floats the event line
            enumOeN_q <= !(!healthyHigh && (insertionFlag || extractionFlag)
                && !enumEventMask);
            // local reset follows pci reset while powered
            // held low until pci reset is released
            lrstOutN_q <= !pciRstActive;
            lrstOeN_q <= healthyHigh;
        end
    end

    assign statusLampDriveN = 1'h0;
    assign statusLampOeN = lampOeN_q;
    assign enumDriveN = 1'h0;
    assign enumOeN = enumOeN_q;
    assign localResetOutN = lrstOutN_q;
    assign localResetOeN = lrstOeN_q;

    // ==========================================================
    // assertions
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    a_lamp_lit_cause: assert property ((healthyHigh || lampOnRequest) |=> !statusLampOeN)
        else $error("lamp not lit while unpowered or requested");

    a_lamp_dark_float: assert property (!(healthyHigh || lampOnRequest) |=> statusLampOeN)
        else $error("lamp driven while it should be dark");

    a_latch_open_sense: assert property ((state_q == ST_RUNNING && !internalReset && latchClosed)
        ##1 (!latchClosed && !internalReset && !extractionFlagWr) |=> extractionFlag)
        else $error("latch low not taken as open");

    a_int_reset_gate: assert property ((healthyHigh || pciRstActive) |=> !configAccept)
        else $error("configuration accepted under internal reset");

    a_unpowered_float: assert property (healthyHigh |=> enumOeN && localResetOeN
        && !statusLampOeN)
        else $error("pins driven while back end unpowered");

    a_local_reset_follow: assert property ((pciRstActive && !healthyHigh)
        |=> !localResetOutN && !localResetOeN)
        else $error("local reset not driven during pci reset");

    a_option_sample: assert property ((healthyPrev_q && !healthyHigh)
        |=> hostConfigHold == $past(pinsSync[PIN_HOLD_OPT]))
        else $error("hold option not sampled on healthy fall");

    a_load_start: assert property ((state_q == ST_WAIT_PCI && !pciRstActive && !healthyHigh
        && eepromLoadEnable) |=> eepromLoadStart ##1 !eepromLoadStart)
        else $error("eeprom load not started on reset release");

    a_insert_after_load: assert property ((state_q == ST_LOADING && eepromLoadDone
        && !internalReset && !hostConfigHold_q) ##1 (!internalReset && !hostConfigHold_q)
        |=> insertionFlag && configAccept)
        else $error("insertion flag missing after load");

    a_hold_retry: assert property (state_q == ST_HOLDING |-> configRetry && !configAccept
        && !insertionFlag)
        else $error("hold state accepts configuration");

    a_ins_clear: assert property ((insertionFlag && insertionFlagWr && !insSet)
        |=> !insertionFlag ##1 (enumOeN || $past(extractionFlag)))
        else $error("insertion flag not cleared by host write");

    a_ext_clear: assert property ((extractionFlagWr && !extSet) |=> !extractionFlag)
        else $error("extraction flag not cleared by host write");

    a_relatch_insert: assert property ((state_q == ST_RUNNING && latchReclosed
        && lampOnRequest && !internalReset) |=> insertionFlag)
        else $error("reclosed latch did not resume insertion");

    a_event_drive: assert property (((insertionFlag || extractionFlag) && !enumEventMask
        && !healthyHigh) |=> !enumOeN)
        else $error("event line not driven for unmasked flag");

    a_one_event: assert property (extSet |-> !$past(ejectorLatchSense, 2)
        && $past(ejectorLatchSense, 3))
        else $error("extraction event not tied to a synchronised latch fall");

    c_insert_done: cover property (state_q == ST_RELEASE ##1 insertionFlag && !enumOeN);
    c_extract: cover property (extSet ##[1:20] extractionFlagWr);
    c_hold_release: cover property (state_q == ST_HOLDING ##1 state_q == ST_RUNNING);
    c_relatch: cover property (latchReclosed && lampOnRequest && state_q == ST_RUNNING);

endmodule : hsf_hot_swap_ctrl

// [dv/hsf_backplane_model.sv]
// backplane side of the card: event line pull-up, front panel lamp, local bus reset line
// assumes the card splits each open-drain pin into a value and an enable that is low
// while the card pulls the line
`timescale 1ns/1ps
module hsf_backplane_model
(
    input wire logic enumDriveN,
    input wire logic enumOeN,
    input wire logic statusLampDriveN,
    input wire logic statusLampOeN,
    input wire logic localResetOutN,
    input wire logic localResetOeN,
    output logic enumLineN,
    output logic lampLit,
    output logic localResetLineN
);
    // ==========================================================
    // wired lines as the host and the operator see them
    // event line idles high
    // backplane pull-up, so a floated line reads released, never a stale low
    assign enumLineN = enumOeN ? 1'h1 : enumDriveN;
    // lamp lit when sunk
    // lamp sits between the supply rail and the pin: dark whenever not sunk
    assign lampLit = !statusLampOeN && !statusLampDriveN;
    assign localResetLineN = localResetOeN ? 1'h1 : localResetOutN;
endmodule : hsf_backplane_model

// [dv/testbench.sv]
// self-checking bench for the card side hot swap control block
// assumes the backplane model resolves the open-drain lines; pins change at falling edges
`timescale 1ns/1ps
module testbench;
    import hsf_pkg::*;
    logic clock = 1'h0, nrst = 1'h0;
    logic healthyN = 1'h1, pciRstN = 1'h0, lrstInN = 1'h1, latch = 1'h1;
    logic holdPin = 1'h0, burstPinN = 1'h1, lampReq = 1'h0, mask = 1'h0;
    logic insWr = 1'h0, extWr = 1'h0, maskWr = 1'h0, holdClr = 1'h0;
    logic loadEn = 1'h0, loadDone = 1'h0, burst = 1'h0;
    logic lampDrvN, lampOeN, enumDrvN, enumOeN, lrstOutN, lrstOeN, intRst;
    logic insFlag, extFlag, hold, burstN, loadStart, cfgAcc, cfgRetry;
    logic enumLineN, lampLit, lrstLineN;
    int error_cnt = 0, comparisons = 0, starts = 0, startsSeen = 0;

    // ==========================================================
    // clock, design and backplane
    always #25 clock = ~clock;
    hsf_hot_swap_ctrl hsf_hot_swap_ctrl_i (.clock(clock), .nrst(nrst),
        .backendHealthyN(healthyN), .pciRstN(pciRstN), .localResetInN(lrstInN),
        .ejectorLatchSense(latch), .hostConfigHoldPin(holdPin), .burstOptionPinN(burstPinN),
        .lampOnRequest(lampReq), .enumEventMask(mask), .insertionFlagWr(insWr),
        .extractionFlagWr(extWr), .enumEventMaskWr(maskWr), .hostConfigHoldClr(holdClr),
        .eepromLoadEnable(loadEn), .eepromLoadDone(loadDone), .statusLampDriveN(lampDrvN),
        .statusLampOeN(lampOeN), .enumDriveN(enumDrvN), .enumOeN(enumOeN),
        .localResetOutN(lrstOutN), .localResetOeN(lrstOeN), .internalReset(intRst),
        .insertionFlag(insFlag), .extractionFlag(extFlag), .hostConfigHold(hold),
        .burstOptionN(burstN), .eepromLoadStart(loadStart), .configAccept(cfgAcc),
        .configRetry(cfgRetry));
    hsf_backplane_model hsf_backplane_model_i (.enumDriveN(enumDrvN), .enumOeN(enumOeN),
        .statusLampDriveN(lampDrvN), .statusLampOeN(lampOeN), .localResetOutN(lrstOutN),
        .localResetOeN(lrstOeN), .enumLineN(enumLineN), .lampLit(lampLit),
        .localResetLineN(lrstLineN));

    // count load starts mid-cycle, away from the edge that launches the pulse
    always @(negedge clock)
        if (loadStart === 1'h1)
            starts++;

    // ==========================================================
    // expectations, compare, verdict
    function automatic logic exp_lamp(input logic hN, input logic req);
        return hN | req;
    endfunction : exp_lamp
    function automatic logic exp_enum_n(input logic insertion_flag, input logic extraction_flag, input logic m);
        return !((insertion_flag | extraction_flag) & !m);
    endfunction : exp_enum_n

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic print_verdict;
        if (error_cnt == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict

    // ==========================================================
    // bus-free host actions and bounded waits
    function automatic logic pick(input int which);
        case (which)
            0: return insFlag;
            1: return extFlag;
            2: return cfgAcc;
            3: return loadStart;
            4: return hold;
            default: return lrstLineN;
        endcase
    endfunction : pick

    task automatic step(input int n);
        repeat (n) @(negedge clock);
    endtask : step

    // a limit that runs out ends the run as a failure
    task automatic wait_for(input int which, input logic val);
        int n;
        n = 0;
        while (pick(which) !== val && n < 40)
        begin
            @(negedge clock);
            n++;
        end
        if (pick(which) !== val)
        begin
            error_cnt++;
            print_verdict();
        end
    endtask : wait_for

    // one-cycle write strobe, held across exactly one rising edge
    task automatic host_write(input int which);
        @(negedge clock);
        insWr = (which == 0);
        extWr = (which == 1);
        maskWr = (which == 2);
        holdClr = (which == 3);
        @(negedge clock);
        {insWr, extWr, maskWr, holdClr} = 4'h0;
    endtask : host_write

    // ==========================================================
    // main sequence
    initial
    begin
        void'($urandom(32'hf5a9));
        step(2);
        check({lampOeN, enumOeN, lrstOeN, insFlag, extFlag}, 5'h0c);
        step(4);
        nrst = 1'h1;
        step(5);
        check({lampLit, enumLineN, lrstOeN, intRst}, 4'hf);
        // late pci reset release with eeprom load
        loadEn = 1'h1;
        burst = 1'($urandom);
        burstPinN = burst;
        mask = 1'($urandom);
        healthyN = 1'h0;
        step(6);
        check({intRst, lrstLineN, starts[3:0]}, 6'h20);
        pciRstN = 1'h1;
        wait_for(3, 1'h1);
        wait_for(5, 1'h1);
        check(intRst, 1'h0);
        step(3);
        check({cfgAcc, insFlag}, 2'h0);
        loadDone = 1'h1;
        step(1);
        loadDone = 1'h0;
        wait_for(0, 1'h1);
        check({cfgAcc, burstN}, {1'h1, burst});
        step(2);
        check(enumLineN, exp_enum_n(1'h1, 1'h0, mask));
        check(lampLit, exp_lamp(healthyN, lampReq));
        host_write(0);
        step(1);
        check({insFlag, enumLineN}, 2'h1);
        // extraction with random mask and random service delay
        for (int i = 0; i < 4; i++)
        begin
            mask = 1'($urandom);
            latch = 1'h0;
            wait_for(1, 1'h1);
            step(2);
            check(enumLineN, exp_enum_n(1'h0, 1'h1, mask));
            step($urandom % 8);
            host_write(1);
            step(6);
            check({extFlag, enumLineN, insFlag}, 3'h2);
            latch = 1'h1;
            step(6);
        end
        // host quiesces, lights the lamp, operator relatches
        mask = 1'h0;
        latch = 1'h0;
        wait_for(1, 1'h1);
        host_write(1);
        lampReq = 1'h1;
        step(4);
        check(lampLit, exp_lamp(healthyN, lampReq));
        startsSeen = starts;
        latch = 1'h1;
        wait_for(0, 1'h1);
        step(2);
        check(enumLineN, 1'h0);
        check(starts - startsSeen, 32'h0);
        mask = 1'h1;
        host_write(2);
        step(1);
        check({insFlag, enumLineN}, 2'h1);
        // board pulled: back end loses power
        healthyN = 1'h1;
        lampReq = 1'h0;
        step(6);
        check({intRst, lampLit, enumLineN, lrstOeN}, 4'hf);
        check({insFlag, cfgAcc}, 2'h0);
        // reinsert with configuration hold
        loadEn = 1'h0;
        holdPin = 1'h1;
        mask = 1'h0;
        healthyN = 1'h0;
        wait_for(4, 1'h1);
        step(10);
        check({cfgAcc, cfgRetry, insFlag, enumLineN}, 4'h5);
        holdPin = 1'h0;
        host_write(3);
        wait_for(0, 1'h1);
        step(2);
        check({cfgAcc, cfgRetry, hold, enumLineN}, 4'h8);
        // local reset input rise resamples the options
        burst = ~burst;
        burstPinN = burst;
        lrstInN = 1'h0;
        step(4);
        lrstInN = 1'h1;
        step(5);
        check(burstN, burst);
        print_verdict();
    end
endmodule : testbench
